// file: bench/psq_ctl_model.sv
// controller stand-in: turns a request into one interrupt pulse
`timescale 1ns/1ps
`default_nettype none
module psq_ctl_model (
    // request from the bench
    input  wire logic       core_clk,
    input  wire logic       go,
    input  wire logic [2:0] kind,
    // interrupt lines, flags qualified by the error/event pulse
    output var  logic       errorEventIrq = 1'b0,
    output var  logic       flagStart = 1'b0,
    output var  logic       flagStop = 1'b0,
    output var  logic       flagArbLost = 1'b0,
    output var  logic       flagNack = 1'b0,
    output var  logic       flagTimeout = 1'b0,
    output var  logic       transmitEndIrq = 1'b0,
    output var  logic       transmitEmptyIrq = 1'b0,
    output var  logic       receiveFullIrq = 1'b0
);
    // flags drop with the pulse so stale levels cannot qualify later
    always @(posedge core_clk) begin
        errorEventIrq    <= go && kind <= 3'h4;
        flagStart        <= go && kind == 3'h0;
        flagStop         <= go && kind == 3'h1;
        flagArbLost      <= go && kind == 3'h2;
        flagNack         <= go && kind == 3'h3;
        flagTimeout      <= go && kind == 3'h4;
        transmitEndIrq   <= go && kind == 3'h5;
        receiveFullIrq   <= go && kind == 3'h6;
        transmitEmptyIrq <= go && kind == 3'h7;
    end
endmodule
`default_nettype wire

// file: bench/psq_props.sv
// port checker for the protocol sequencer
`timescale 1ns/1ps
`default_nettype none
module psq_props (
    // clock, reset and apb
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pwrite,
    input wire logic       pready,
    input wire logic       pslverr,
    // controller requests
    input wire logic       errorEventIrq,
    input wire logic       transmitEndIrq,
    input wire logic       transmitEmptyIrq,
    input wire logic       receiveFullIrq,
    // handler side
    input wire logic       handlerStrobe,
    input wire logic [3:0] handlerCode,
    input wire logic       errorPulse
);
    logic [3:0] gap;
    logic       ini;
    logic       tmo;
    wire logic  ev = errorEventIrq | transmitEndIrq | transmitEmptyIrq
                   | receiveFullIrq | (psel & penable & pready & pwrite);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////
    // age of the last possible cause, saturating so it never wraps
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) gap <= 4'h0;
        else if (ev) gap <= 4'h0;
        else if (gap != 4'hf) gap <= gap + 4'h1;
    end
    // history flags: initialised, timed out (only reset leaves it)
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ini <= 1'b0;
            tmo <= 1'b0;
        end else if (handlerStrobe) begin
            ini <= ini | (handlerCode == 4'h0 && !errorPulse);
            tmo <= tmo | (handlerCode == 4'hb);
        end
    end
    ////////////////////////////////////////////////////////////////
    AST_ERR_CODE: assert property (errorPulse |-> handlerStrobe && handlerCode == 4'hf)
        else $error("error pulse without error code");
    AST_OK_CODE: assert property (handlerStrobe && !errorPulse |-> handlerCode != 4'hf)
        else $error("accepted event shows error code");
    AST_CAUSE: assert property (handlerStrobe |-> gap <= 4'h8)
        else $error("handler ran with no event");
    AST_UNINIT: assert property (handlerStrobe && !ini |-> handlerCode inside {4'h0,4'hf})
        else $error("event accepted before initialise");
    AST_TMO_LOCK: assert property (handlerStrobe && tmo |-> errorPulse)
        else $error("event accepted after timeout");
    AST_HELD: assert property (!handlerStrobe |-> $stable(handlerCode))
        else $error("handler code moved without strobe");
    AST_READY: assert property (pready |-> $past(psel && !penable) && penable)
        else $error("ready outside access phase");
    AST_READY_ONE: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    AST_SLVERR: assert property (pslverr |-> pready)
        else $error("slave error without ready");
    cover property (handlerStrobe && handlerCode == 4'h5);
    cover property (errorPulse);
    cover property (pslverr);
endmodule
`default_nettype wire

// file: bench/psq_sequencer_bench.sv
// self-checking bench of the protocol sequencer
`timescale 1ns/1ps
`default_nettype none
module psq_sequencer_bench;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        go = 1'b0;
    logic [2:0]  kind = 3'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, er, hs, ep, irq;
    logic        error_event_irq, fSt, fSp, fAl, fNk, fTo, transmit_end_irq, transmit_empty_irq, receive_full_irq;
    logic [3:0]  hc;
    int          mismatches = 0;
    int          checked = 0;
    always #12.5 core_clk = ~core_clk;
    psq_sequencer dut_u (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .errorEventIrq(error_event_irq), .flagStart(fSt), .flagStop(fSp),
        .flagArbLost(fAl), .flagNack(fNk), .flagTimeout(fTo), .transmitEndIrq(transmit_end_irq),
        .transmitEmptyIrq(transmit_empty_irq), .receiveFullIrq(receive_full_irq), .handlerStrobe(hs),
        .handlerCode(hc), .errorPulse(ep), .irq);
    psq_ctl_model ctl_u (.core_clk, .go, .kind, .errorEventIrq(error_event_irq), .flagStart(fSt),
        .flagStop(fSp), .flagArbLost(fAl), .flagNack(fNk), .flagTimeout(fTo),
        .transmitEndIrq(transmit_end_irq), .transmitEmptyIrq(transmit_empty_irq), .receiveFullIrq(receive_full_irq));
    ////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one apb transfer; request held until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // wait for the handler strobe, then judge its code
    task automatic hit(input logic [3:0] e);
        do @(posedge core_clk); while (hs !== 1'b1);
        cmp(hc, e);
        cmp(ep, e == 4'hf);
    endtask
    task automatic ev(input logic [2:0] k, input logic [3:0] e);
        @(posedge core_clk);
        go <= 1'b1;
        kind <= k;
        @(posedge core_clk);
        go <= 1'b0;
        hit(e);
    endtask
    task automatic cm(input logic [31:0] d, input logic [3:0] e);
        apb(1'b1, 8'h00, d);
        hit(e);
    endtask
    task automatic st(input logic [31:0] s);
        apb(1'b0, 8'h04, 32'h0);
        cmp(rd & 32'h7ff, s);
    endtask
    task automatic wrap_up;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // kinds: 0 start 1 stop 2 arb 3 nack 4 timeout 5 tx-end 6 rx 7 tx-empty
    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        ev(3'h0, 4'hf);
        cm(32'h4, 4'hf);
        cm(32'h1, 4'h0);
        st(32'h002);
        apb(1'b1, 8'h0c, 32'h2);
        ev(3'h6, 4'hf);
        cm(32'h104, 4'h1);
        ev(3'h5, 4'hf);
        ev(3'h0, 4'h2);
        st(32'h010);
        ev(3'h6, 4'hf);
        ev(3'h5, 4'h3);
        ev(3'h6, 4'hf);
        ev(3'h1, 4'hf);
        ev(3'h7, 4'h5);
        st(32'h100);
        cmp(irq, 1'b0);
        ev(3'h2, 4'hf);
        ev(3'h1, 4'h7);
        st(32'h002);
        cmp(irq, 1'b1);
        apb(1'b0, 8'h08, 32'h0);
        cmp(rd, 32'h3);
        apb(1'b0, 8'h08, 32'h0);
        cmp(rd, 32'h0);
        cmp(irq, 1'b0);
        apb(1'b0, 8'h0c, 32'h0);
        cmp(rd, 32'h2);
        apb(1'b0, 8'h14, 32'h0);
        cmp(er, 1'b1);
        cm(32'h10c, 4'h1);
        ev(3'h0, 4'h2);
        ev(3'h5, 4'hf);
        ev(3'h6, 4'h3);
        ev(3'h7, 4'hf);
        ev(3'h6, 4'h6);
        ev(3'h3, 4'h9);
        st(32'h100);
        ev(3'h1, 4'h7);
        cm(32'h104, 4'h1);
        ev(3'h2, 4'h8);
        st(32'h200);
        ev(3'h3, 4'hf);
        ev(3'h5, 4'h5);
        ev(3'h1, 4'h7);
        cm(32'h104, 4'h1);
        ev(3'h0, 4'h2);
        ev(3'h4, 4'hb);
        st(32'h400);
        ev(3'h4, 4'hf);
        cm(32'h1, 4'hf);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        cm(32'h1, 4'h0);
        cm(32'h2, 4'ha);
        st(32'h004);
        cm(32'h2, 4'hf);
        ev(3'h5, 4'h4);
        ev(3'h3, 4'h9);
        ev(3'h1, 4'h7);
        ev(3'h6, 4'h4);
        st(32'h080);
        wrap_up;
    end
    // hang guard, well past the expected run length
    initial begin
        #100000;
        mismatches++;
        wrap_up;
    end
endmodule
bind psq_sequencer psq_props chk_u (.core_clk, .rst, .psel, .penable, .pwrite, .pready,
    .pslverr, .errorEventIrq, .transmitEndIrq, .transmitEmptyIrq, .receiveFullIrq,
    .handlerStrobe, .handlerCode, .errorPulse);
`default_nettype wire

// file: inc/psq_map.svh
// register map, field positions and event/handler codes of the protocol sequencer
// Overview of operation
// - state changes only on an event: a host command or a controller interrupt
// - initialise, enable-slave and master-start commands count as events like interrupts
// - master-only idle: master start makes start condition, enable-slave arms slave
// - slave-armed idle: master start makes start condition, address/receive events run address match
// - start wait: start-seen event runs post-start processing toward address send
// - write-address wait: address-done event runs post-address; data/receive are errors
// - read-address wait: only receive event completes address; address-done is error
// - send wait: send event transmits next byte; receive/start/stop are errors
// - receive wait: receive event reads byte; send and stop are errors
// - stop wait: stop-seen ends communication; arbitration-lost is an error
// - arbitration-lost handled in start, address, send and receive waits
// - not-acknowledge handled in every wait state from start through stop
// - timeout handled in every wait state from start through stop
// - after arbitration loss send, receive and stop still serviced; rest error
// - timed-out state rejects every event as error
// - unexpected event gives error result and error processing, no transition
// - transmit irqs map to address-done or send event by state alone
// - uninitialised state accepts only the initialise command
`ifndef PSQ_MAP_SVH
`define PSQ_MAP_SVH
// register byte offsets
`define PSQ_CMD_OFS        8'h00
`define PSQ_STATE_OFS      8'h04
`define PSQ_STATUS_OFS     8'h08
`define PSQ_MASK_OFS       8'h0c
`define PSQ_LAST_OFS       8'h10
// command register fields
`define PSQ_CMD_INIT       0
`define PSQ_CMD_ENSLV      1
`define PSQ_CMD_MSTART     2
`define PSQ_CMD_READ       3
`define PSQ_CMD_CNT_LO     8
`define PSQ_CMD_CNT_HI     15
// status / mask bits
`define PSQ_ST_ERR         0
`define PSQ_ST_DONE        1
`define PSQ_ST_ARB         2
`define PSQ_ST_NACK        3
`define PSQ_ST_TMO         4
`define PSQ_ST_SLV         5
`define PSQ_ST_W           6
`define PSQ_MASK_RST       6'h00
// raw controller sources in the pending vector
`define PSQ_SRC_START      0
`define PSQ_SRC_STOP       1
`define PSQ_SRC_AL         2
`define PSQ_SRC_NACK       3
`define PSQ_SRC_TMO        4
`define PSQ_SRC_TX         5
`define PSQ_SRC_RX         6
`define PSQ_SRC_N          7
// event codes
`define PSQ_EV_INIT        4'h0
`define PSQ_EV_ENSLV       4'h1
`define PSQ_EV_MSTART      4'h2
`define PSQ_EV_START       4'h3
`define PSQ_EV_ADDR        4'h4
`define PSQ_EV_TX          4'h5
`define PSQ_EV_RX          4'h6
`define PSQ_EV_STOP        4'h7
`define PSQ_EV_AL          4'h8
`define PSQ_EV_NACK        4'h9
`define PSQ_EV_TMO         4'ha
// handler codes
`define PSQ_FN_INIT        4'h0
`define PSQ_FN_GENSTART    4'h1
`define PSQ_FN_AFTSTART    4'h2
`define PSQ_FN_AFTADDR     4'h3
`define PSQ_FN_SLVMATCH    4'h4
`define PSQ_FN_TXDATA      4'h5
`define PSQ_FN_RXDATA      4'h6
`define PSQ_FN_END         4'h7
`define PSQ_FN_ARB         4'h8
`define PSQ_FN_NACK        4'h9
`define PSQ_FN_ENSLV       4'ha
`define PSQ_FN_TMO         4'hb
`define PSQ_FN_ERR         4'hf
`endif

// file: inc/psq_pkg.sv
// types of the protocol sequencer
package psq_pkg;
    typedef enum logic [10:0] {
        st_no_init          = 11'h001,
        st_idle             = 11'h002,
        st_idle_slave_armed = 11'h004,
        st_wait_start       = 11'h008,
        st_wait_addr_wr     = 11'h010,
        st_wait_addr_rd     = 11'h020,
        st_wait_tx          = 11'h040,
        st_wait_rx          = 11'h080,
        st_wait_stop        = 11'h100,
        st_arb_lost         = 11'h200,
        st_timed_out        = 11'h400
    } psq_state_t;
    typedef enum logic [1:0] {
        md_none   = 2'h0,
        md_m_send = 2'h1,
        md_m_recv = 2'h2,
        md_s_rdy  = 2'h3
    } psq_mode_t;
endpackage

// file: verilog/psq_sequencer.sv
// event-driven two-wire bus protocol sequencer with apb register access
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "psq_map.svh"
module psq_sequencer
    import psq_pkg::*;
#(
    parameter int CNT_W = 8
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // controller interrupt requests, one-cycle pulses
    input  wire logic        errorEventIrq,
    input  wire logic        flagStart,
    input  wire logic        flagStop,
    input  wire logic        flagArbLost,
    input  wire logic        flagNack,
    input  wire logic        flagTimeout,
    input  wire logic        transmitEndIrq,
    input  wire logic        transmitEmptyIrq,
    input  wire logic        receiveFullIrq,
    // handler requests to the controller
    output var  logic        handlerStrobe,
    output var  logic [3:0]  handlerCode,
    output var  logic        errorPulse,
    // interrupt to software
    output var  logic        irq
);

    ////////////////////////////////////////////////////////////////////////
    // state

    psq_state_t              state;
    psq_state_t              next_state;
    psq_mode_t               mode;
    psq_mode_t               next_mode;
    logic [CNT_W-1:0]        byteLeft;
    logic [CNT_W-1:0]        next_byteLeft;
    logic [CNT_W-1:0]        cmdCount;
    logic                    cmdPend;
    logic [3:0]              cmdCode;
    logic                    cmdRead;
    logic [`PSQ_SRC_N-1:0]   pend;
    logic [`PSQ_SRC_N-1:0]   rawSrc;
    logic [`PSQ_SRC_N-1:0]   take;
    logic                    hasEv;
    logic [3:0]              evCode;
    logic [3:0]              fn;
    logic                    isErr;
    logic [`PSQ_ST_W-1:0]    status;
    logic [`PSQ_ST_W-1:0]    mask;
    logic [`PSQ_ST_W-1:0]    setSt;
    logic [3:0]              lastEv;
    logic [3:0]              lastFn;
    logic                    apbWr;
    logic                    apbRd;
    logic                    mapped;

    ////////////////////////////////////////////////////////////////////////
    // apb decode

    assign apbWr = psel & penable & pready & pwrite;
    assign apbRd = psel & penable & pready & ~pwrite;

    // address decode as an if chain
    always_comb begin
        if (paddr == `PSQ_CMD_OFS) begin
            mapped = 1'b1;
        end else if (paddr == `PSQ_STATE_OFS) begin
            mapped = 1'b1;
        end else if (paddr == `PSQ_STATUS_OFS) begin
            mapped = 1'b1;
        end else if (paddr == `PSQ_MASK_OFS) begin
            mapped = 1'b1;
        end else if (paddr == `PSQ_LAST_OFS) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    // no wait state: ready is raised for the first access cycle only
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
        end
    end

    // read data captured in the setup cycle, so it is a flop at the access edge
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel & ~penable & ~pwrite) begin
            if (paddr == `PSQ_STATE_OFS) begin
                prdata <= {8'h00, byteLeft, 3'h0, mode, state};
            end else if (paddr == `PSQ_STATUS_OFS) begin
                prdata <= {{(32-`PSQ_ST_W){1'b0}}, status | setSt};
            end else if (paddr == `PSQ_MASK_OFS) begin
                prdata <= {{(32-`PSQ_ST_W){1'b0}}, mask};
            end else if (paddr == `PSQ_LAST_OFS) begin
                prdata <= {24'h00_0000, lastFn, lastEv};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // host commands become events

    // a later command overwrites one still pending; commands are taken next cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cmdPend  <= 1'b0;
            cmdCode  <= `PSQ_EV_INIT;
            cmdRead  <= 1'b0;
            cmdCount <= '0;
        end else if (apbWr && paddr == `PSQ_CMD_OFS &&
                     (pwdata[`PSQ_CMD_INIT] | pwdata[`PSQ_CMD_ENSLV] |
                      pwdata[`PSQ_CMD_MSTART])) begin
            cmdPend  <= 1'b1;
            cmdRead  <= pwdata[`PSQ_CMD_READ];
            cmdCount <= pwdata[`PSQ_CMD_CNT_LO +: CNT_W];
            if (pwdata[`PSQ_CMD_INIT]) begin
                cmdCode <= `PSQ_EV_INIT;
            end else if (pwdata[`PSQ_CMD_ENSLV]) begin
                cmdCode <= `PSQ_EV_ENSLV;
            end else begin
                cmdCode <= `PSQ_EV_MSTART;
            end
        end else begin
            cmdPend <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // controller interrupts held until serviced

    assign rawSrc[`PSQ_SRC_START] = errorEventIrq & flagStart;
    assign rawSrc[`PSQ_SRC_STOP]  = errorEventIrq & flagStop;
    assign rawSrc[`PSQ_SRC_AL]    = errorEventIrq & flagArbLost;
    assign rawSrc[`PSQ_SRC_NACK]  = errorEventIrq & flagNack;
    assign rawSrc[`PSQ_SRC_TMO]   = errorEventIrq & flagTimeout;
    assign rawSrc[`PSQ_SRC_TX]    = transmitEndIrq | transmitEmptyIrq;
    assign rawSrc[`PSQ_SRC_RX]    = receiveFullIrq;

    // a new request in the cycle its pending bit is serviced is kept
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pend <= '0;
        end else begin
            pend <= (pend & ~take) | rawSrc;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // event selection: commands first, then faults, then progress events

    always_comb begin
        hasEv  = cmdPend | (|pend); // every pending source is one event
        take   = '0;
        evCode = `PSQ_EV_INIT;
        if (cmdPend) begin
            evCode = cmdCode;
        end else if (pend[`PSQ_SRC_TMO]) begin
            take[`PSQ_SRC_TMO] = 1'b1;
            evCode = `PSQ_EV_TMO;
        end else if (pend[`PSQ_SRC_AL]) begin
            take[`PSQ_SRC_AL] = 1'b1;
            evCode = `PSQ_EV_AL;
        end else if (pend[`PSQ_SRC_NACK]) begin
            take[`PSQ_SRC_NACK] = 1'b1;
            evCode = `PSQ_EV_NACK;
        end else if (pend[`PSQ_SRC_START]) begin
            take[`PSQ_SRC_START] = 1'b1;
            evCode = `PSQ_EV_START;
        end else if (pend[`PSQ_SRC_TX]) begin
            take[`PSQ_SRC_TX] = 1'b1;
            // address phases turn transmit irqs into address-done
            if (state == st_idle_slave_armed || state == st_wait_addr_wr ||
                state == st_wait_addr_rd) begin
                evCode = `PSQ_EV_ADDR;
            end else begin
                evCode = `PSQ_EV_TX;
            end
        end else if (pend[`PSQ_SRC_RX]) begin
            take[`PSQ_SRC_RX] = 1'b1;
            evCode = `PSQ_EV_RX;
        end else if (pend[`PSQ_SRC_STOP]) begin
            take[`PSQ_SRC_STOP] = 1'b1;
            evCode = `PSQ_EV_STOP;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transition table

    always_comb begin
        next_state    = state;
        next_mode     = mode;
        next_byteLeft = byteLeft;
        fn            = `PSQ_FN_ERR;
        case (state)
            st_no_init: if (evCode == `PSQ_EV_INIT) fn = `PSQ_FN_INIT;
            st_idle: begin
                if (evCode == `PSQ_EV_INIT) begin
                    fn = `PSQ_FN_INIT;
                end else if (evCode == `PSQ_EV_MSTART) begin
                    fn = `PSQ_FN_GENSTART;
                end else if (evCode == `PSQ_EV_ENSLV) begin
                    fn = `PSQ_FN_ENSLV;
                end
            end
            st_idle_slave_armed: begin
                if (evCode == `PSQ_EV_INIT) begin
                    fn = `PSQ_FN_INIT;
                end else if (evCode == `PSQ_EV_MSTART) begin
                    fn = `PSQ_FN_GENSTART;
                end else if (evCode == `PSQ_EV_ADDR || evCode == `PSQ_EV_RX) begin
                    fn = `PSQ_FN_SLVMATCH;
                end
            end
            st_wait_start:   if (evCode == `PSQ_EV_START) fn = `PSQ_FN_AFTSTART;
            st_wait_addr_wr: if (evCode == `PSQ_EV_ADDR) fn = `PSQ_FN_AFTADDR;
            st_wait_addr_rd: if (evCode == `PSQ_EV_RX) fn = `PSQ_FN_AFTADDR;
            st_wait_tx:      if (evCode == `PSQ_EV_TX) fn = `PSQ_FN_TXDATA;
            st_wait_rx:      if (evCode == `PSQ_EV_RX) fn = `PSQ_FN_RXDATA;
            st_wait_stop:    if (evCode == `PSQ_EV_STOP) fn = `PSQ_FN_END;
            st_arb_lost: begin
                if (evCode == `PSQ_EV_TX) begin
                    fn = `PSQ_FN_TXDATA;
                end else if (evCode == `PSQ_EV_RX) begin
                    fn = `PSQ_FN_RXDATA;
                end else if (evCode == `PSQ_EV_STOP) begin
                    fn = `PSQ_FN_END;
                end
            end
            st_timed_out:    fn = `PSQ_FN_ERR;
            default:         fn = `PSQ_FN_ERR;
        endcase
        // fault events override the per-state entries in the wait states; arbitration loss does not in the stop wait
        if (evCode == `PSQ_EV_AL && (state == st_wait_start ||
            state == st_wait_addr_wr || state == st_wait_addr_rd ||
            state == st_wait_tx || state == st_wait_rx)) begin
            fn = `PSQ_FN_ARB;
        end
        if ((evCode == `PSQ_EV_NACK || evCode == `PSQ_EV_TMO) &&
            (state == st_wait_start || state == st_wait_addr_wr ||
             state == st_wait_addr_rd || state == st_wait_tx ||
             state == st_wait_rx || state == st_wait_stop)) begin
            fn = (evCode == `PSQ_EV_NACK) ? `PSQ_FN_NACK : `PSQ_FN_TMO;
        end
        isErr = (fn == `PSQ_FN_ERR);
        // the handler decides the next state; an error leaves it alone
        case (fn)
            `PSQ_FN_INIT: begin
                next_state    = st_idle;
                next_mode     = md_none;
                next_byteLeft = '0;
            end
            `PSQ_FN_GENSTART: begin
                next_state    = st_wait_start;
                next_mode     = cmdRead ? md_m_recv : md_m_send;
                next_byteLeft = cmdCount;
            end
            `PSQ_FN_AFTSTART: begin
                next_state = (mode == md_m_recv) ? st_wait_addr_rd : st_wait_addr_wr;
            end
            `PSQ_FN_AFTADDR: begin
                next_state = (mode == md_m_recv) ? st_wait_rx : st_wait_tx;
            end
            `PSQ_FN_SLVMATCH: begin
                next_state = (evCode == `PSQ_EV_RX) ? st_wait_rx : st_wait_tx;
            end
            `PSQ_FN_TXDATA, `PSQ_FN_RXDATA: begin
                // the last byte of a master transfer moves on to the stop wait unless arbitration was lost
                if (byteLeft > 1) begin
                    next_byteLeft = byteLeft - 1'b1;
                end else begin
                    next_byteLeft = '0;
                    if (state != st_arb_lost && mode != md_s_rdy) begin
                        next_state = st_wait_stop;
                    end
                end
            end
            `PSQ_FN_END: begin
                next_state = (mode == md_s_rdy) ? st_idle_slave_armed : st_idle;
                next_mode  = (mode == md_s_rdy) ? md_s_rdy : md_none;
            end
            `PSQ_FN_ARB:  next_state = st_arb_lost;
            `PSQ_FN_NACK: next_state = st_wait_stop;
            `PSQ_FN_ENSLV: begin
                next_state    = st_idle_slave_armed;
                next_mode     = md_s_rdy;
                next_byteLeft = cmdCount;
            end
            `PSQ_FN_TMO:  next_state = st_timed_out;
            default:      next_state = state;
        endcase
    end

    // state moves only when an event is present
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state    <= st_no_init;
            mode     <= md_none;
            byteLeft <= '0;
        end else if (hasEv) begin
            state    <= next_state;
            mode     <= next_mode;
            byteLeft <= next_byteLeft;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // handler requests and last event record

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            handlerStrobe <= 1'b0;
            handlerCode   <= `PSQ_FN_ERR;
            errorPulse    <= 1'b0;
            lastEv        <= `PSQ_EV_INIT;
            lastFn        <= `PSQ_FN_ERR;
        end else begin
            handlerStrobe <= hasEv;
            errorPulse    <= hasEv & isErr;
            if (hasEv) begin
                handlerCode <= fn;
                lastEv      <= evCode;
                lastFn      <= fn;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky status, read to clear, mask and interrupt

    always_comb begin
        setSt = '0;
        setSt[`PSQ_ST_ERR]  = hasEv & isErr;
        setSt[`PSQ_ST_DONE] = hasEv & (fn == `PSQ_FN_END);
        setSt[`PSQ_ST_ARB]  = hasEv & (fn == `PSQ_FN_ARB);
        setSt[`PSQ_ST_NACK] = hasEv & (fn == `PSQ_FN_NACK);
        setSt[`PSQ_ST_TMO]  = hasEv & (fn == `PSQ_FN_TMO);
        setSt[`PSQ_ST_SLV]  = hasEv & (fn == `PSQ_FN_SLVMATCH);
    end

    // a set in the clearing read's cycle survives; it was not shown in that read, whose data was captured in the setup cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            status <= '0;
        end else if (apbRd && paddr == `PSQ_STATUS_OFS) begin
            status <= setSt;
        end else begin
            status <= status | setSt;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mask <= `PSQ_MASK_RST;
        end else if (apbWr && paddr == `PSQ_MASK_OFS) begin
            mask <= pwdata[`PSQ_ST_W-1:0];
        end
    end

    // level interrupt, one cycle behind the status bit
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & mask);
        end
    end

endmodule
`default_nettype wire
